// File: hw/pvip_top.sv
// Design decisions made here: the address map and the APB register port.
`include "pvip_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module pvip_top
  import pvip_pkg::*;
#(
  parameter int FIFO_DEPTH = `PVIP_FIFO_DEPTH
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  // apb slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`PVIP_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // parallel video pins
  input  wire logic                    i_pclk,
  input  wire logic [9:0]              i_din,
  input  wire logic                    i_field_or_active_pin,
  input  wire logic                    i_hflag_or_hsync_pin,
  input  wire logic                    i_vflag_or_vsync_pin,
  // captured word stream
  output pvip_word_t                   o_word,
  output logic                         o_word_valid,
  input  wire logic                    i_word_ready
);

  // ****************************************
  // pin synchronisers and clock edge
  // ****************************************
  pvip_pins_t pins_now;
  pvip_pins_t meta_reg;
  pvip_pins_t sync_reg;
  logic       pclk_prev_reg;
  logic       pclk_rise;

  assign pins_now = '{din:  i_din,
                      fpin: i_field_or_active_pin,
                      hpin: i_hflag_or_hsync_pin,
                      vpin: i_vflag_or_vsync_pin,
                      clk:  i_pclk};

  // data and clock travel through equal depth, so the word stays aligned to its edge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_reg      <= '0;
      sync_reg      <= '0;
      pclk_prev_reg <= 1'b0;
    end else begin
      meta_reg      <= pins_now;
      sync_reg      <= meta_reg;
      pclk_prev_reg <= sync_reg.clk;
    end
  end

  assign pclk_rise = sync_reg.clk && !pclk_prev_reg;

  // ****************************************
  // apb register file
  // ****************************************
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic        ovfl_reg;
  logic        ovfl_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        apb_wr;
  logic        apb_setup;
  logic        addr_hit;
  logic        mode_change;
  logic        bad_mode;
  logic        overflow_evt;
  logic        accept_evt;
  logic        fifo_empty;

  assign apb_wr    = i_psel && i_penable && i_pwrite;
  assign apb_setup = i_psel && !i_penable;
  assign addr_hit  = (i_paddr == `PVIP_CTRL_OFS) || (i_paddr == `PVIP_STATUS_OFS) ||
                     (i_paddr == `PVIP_COUNT_OFS);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata  = prdata_reg;

  // a change to any mode select restarts word framing
  assign mode_change = apb_wr && (i_paddr == `PVIP_CTRL_OFS) &&
                       (i_pwdata[`PVIP_MODE_MSB:0] != ctrl_reg[`PVIP_MODE_MSB:0]);

  // register next values; overflow set wins over a write-one clear
  always_comb begin
    ctrl_next   = ctrl_reg;
    ovfl_next   = ovfl_reg;
    count_next  = count_reg;
    prdata_next = prdata_reg;
    if (apb_wr && (i_paddr == `PVIP_CTRL_OFS)) begin
      ctrl_next = i_pwdata[7:0];
    end
    if (apb_wr && (i_paddr == `PVIP_STATUS_OFS) && i_pwdata[`PVIP_STAT_OVFL]) begin
      ovfl_next = 1'b0;
    end
    if (overflow_evt) begin
      ovfl_next = 1'b1;
    end
    if (accept_evt) begin
      count_next = count_reg + 32'h0000_0001;
    end
    // read data is fetched in the setup cycle so the access cycle sees a flop
    if (apb_setup && !i_pwrite) begin
      case (i_paddr)
        `PVIP_CTRL_OFS: begin
          prdata_next = {24'h00_0000, ctrl_reg};
        end
        `PVIP_STATUS_OFS: begin
          prdata_next = {29'h0000_0000, fifo_empty, bad_mode, ovfl_reg};
        end
        `PVIP_COUNT_OFS: begin
          prdata_next = count_reg;
        end
        default: begin
          prdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg   <= `PVIP_CTRL_RESET;
      ovfl_reg   <= 1'b0;
      count_reg  <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      ovfl_reg   <= ovfl_next;
      count_reg  <= count_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  logic      rate_select;
  logic      bus_width_select;
  logic      smpte_processing_select;
  logic      asi_mode_select;
  logic      sync_style_select;
  logic      auto_timing_detect_select;
  logic      io_processing_enable;
  logic      port_enable;
  pvip_fmt_t fmt;

  assign rate_select               = ctrl_reg[`PVIP_CTRL_RATE];
  assign bus_width_select          = ctrl_reg[`PVIP_CTRL_WIDTH];
  assign smpte_processing_select   = ctrl_reg[`PVIP_CTRL_SMPTE];
  assign asi_mode_select           = ctrl_reg[`PVIP_CTRL_ASI];
  assign sync_style_select         = ctrl_reg[`PVIP_CTRL_SYNC];
  assign auto_timing_detect_select = ctrl_reg[`PVIP_CTRL_AUTO];
  assign io_processing_enable      = ctrl_reg[`PVIP_CTRL_IOPROC];
  assign port_enable               = ctrl_reg[`PVIP_CTRL_ENABLE];

  // smpte wins over the asi select; asi at hd rate is refused
  always_comb begin
    if (smpte_processing_select) begin
      fmt = PVIP_FMT_SMPTE;
    end else if (!asi_mode_select) begin
      fmt = PVIP_FMT_THRU;
    end else if (rate_select) begin
      fmt = PVIP_FMT_ASI;
    end else begin
      fmt = PVIP_FMT_BAD;
    end
  end

  assign bad_mode = (fmt == PVIP_FMT_BAD);

  // ****************************************
  // trs framing and timing flags
  // ****************************************
  pvip_trs_t  trs_reg;
  pvip_trs_t  trs_next;
  logic       chroma_reg;
  logic       chroma_next;
  logic [2:0] fvh_reg;
  logic [2:0] fvh_next;
  logic       take;
  logic       use_trs;
  logic       is_xyz;
  logic [9:0] din_w;
  pvip_word_t word_c;

  assign din_w   = sync_reg.din;
  assign take    = pclk_rise && port_enable && !bad_mode;
  assign use_trs = (fmt == PVIP_FMT_SMPTE);
  assign is_xyz  = use_trs && (trs_reg == PVIP_TRS_XYZ);

  // search for the 3ff 000 000 preamble; words outside smpte mode are never framed
  always_comb begin
    trs_next    = trs_reg;
    chroma_next = chroma_reg;
    fvh_next    = fvh_reg;
    if (mode_change) begin
      trs_next    = PVIP_TRS_IDLE;
      chroma_next = 1'b1;
    end else if (take && use_trs) begin
      case (trs_reg)
        PVIP_TRS_IDLE: begin
          trs_next = (din_w == `PVIP_TRS_PRE) ? PVIP_TRS_ONE : PVIP_TRS_IDLE;
        end
        PVIP_TRS_ONE: begin
          trs_next = (din_w == `PVIP_TRS_ZERO) ? PVIP_TRS_TWO :
                     (din_w == `PVIP_TRS_PRE) ? PVIP_TRS_ONE : PVIP_TRS_IDLE;
        end
        PVIP_TRS_TWO: begin
          trs_next = (din_w == `PVIP_TRS_ZERO) ? PVIP_TRS_XYZ :
                     (din_w == `PVIP_TRS_PRE) ? PVIP_TRS_ONE : PVIP_TRS_IDLE;
        end
        PVIP_TRS_XYZ: begin
          trs_next = PVIP_TRS_IDLE;
        end
        default: begin
          trs_next = PVIP_TRS_IDLE;
        end
      endcase
      // after each xyz word the next sample is chroma; otherwise alternate
      chroma_next = is_xyz ? 1'b1 : !chroma_reg;
      if (is_xyz) begin
        fvh_next = {din_w[`PVIP_XYZ_F], din_w[`PVIP_XYZ_V], din_w[`PVIP_XYZ_H]};
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      trs_reg    <= PVIP_TRS_IDLE;
      chroma_reg <= 1'b1;
      fvh_reg    <= 3'h0;
    end else begin
      trs_reg    <= trs_next;
      chroma_reg <= chroma_next;
      fvh_reg    <= fvh_next;
    end
  end

  // ****************************************
  // word assembly
  // ****************************************
  // timing comes from pins or from the embedded xyz bits, never a mix
  always_comb begin
    word_c        = '0;
    word_c.data   = din_w;
    word_c.fmt    = fmt;
    word_c.trs    = is_xyz || (use_trs && (trs_reg != PVIP_TRS_IDLE)) ||
                    (use_trs && (din_w == `PVIP_TRS_PRE));
    // luma only in 20-bit width, interleaved in 10-bit width
    word_c.chroma = use_trs && !bus_width_select && chroma_reg && !word_c.trs;
    if (use_trs && auto_timing_detect_select) begin
      // pins are not looked at here at all
      word_c.f = is_xyz ? din_w[`PVIP_XYZ_F] : fvh_reg[2];
      word_c.v = is_xyz ? din_w[`PVIP_XYZ_V] : fvh_reg[1];
      word_c.h = is_xyz ? din_w[`PVIP_XYZ_H] : fvh_reg[0];
    end else if (sync_style_select) begin
      // active enable and the vsync pulse carry timing; the hsync pin is not used
      word_c.f = 1'b0;
      word_c.h = !sync_reg.fpin;
      word_c.v = sync_reg.vpin;
    end else begin
      word_c.f = sync_reg.fpin;
      word_c.h = sync_reg.hpin;
      word_c.v = sync_reg.vpin;
    end
    word_c.active = !word_c.h && !word_c.v && !word_c.trs;
    // the field flag forces F into every xyz word while processing is on and auto detect and sync style are off
    if (is_xyz && io_processing_enable && !auto_timing_detect_select &&
        !sync_style_select && sync_reg.fpin) begin
      word_c.data[`PVIP_XYZ_F] = 1'b1;
      word_c.f                 = 1'b1;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  logic fifo_ready;

  // the source cannot be stalled, so a full buffer loses the word and flags it
  // a word taken on the flush edge is dropped by the buffer, so it is not counted
  assign accept_evt   = take && fifo_ready && !mode_change;
  assign overflow_evt = take && !fifo_ready;
  assign fifo_empty   = !o_word_valid;

  pvip_fifo #(
    .WIDTH ($bits(pvip_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_flush (mode_change),
    .i_data  (word_c),
    .i_valid (take),
    .o_ready (fifo_ready),
    .o_data  (o_word),
    .o_valid (o_word_valid),
    .i_ready (i_word_ready)
  );

endmodule

`default_nettype wire

// File: hw/pvip_consts.svh
`ifndef PVIP_CONSTS_SVH
`define PVIP_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define PVIP_ADDR_W        12
`define PVIP_CTRL_OFS      12'h000
`define PVIP_STATUS_OFS    12'h004
`define PVIP_COUNT_OFS     12'h008
`define PVIP_CTRL_RESET    8'hC4

// ****************************************
// control and status fields
// ****************************************
`define PVIP_CTRL_RATE     0
`define PVIP_CTRL_WIDTH    1
`define PVIP_CTRL_SMPTE    2
`define PVIP_CTRL_ASI      3
`define PVIP_CTRL_SYNC     4
`define PVIP_CTRL_AUTO     5
`define PVIP_CTRL_IOPROC   6
`define PVIP_CTRL_ENABLE   7
`define PVIP_MODE_MSB      6
`define PVIP_STAT_OVFL     0
`define PVIP_STAT_BADMODE  1
`define PVIP_STAT_EMPTY    2

// ****************************************
// timing reference words and buffer depth
// ****************************************
`define PVIP_TRS_PRE       10'h3FF
`define PVIP_TRS_ZERO      10'h000
`define PVIP_XYZ_F         8
`define PVIP_XYZ_V         7
`define PVIP_XYZ_H         6
`define PVIP_FIFO_DEPTH    8

`endif

// File: hw/pvip_pkg.sv
package pvip_pkg;

  // ****************************************
  // formatting of the incoming words
  // ****************************************
  typedef enum logic [1:0] {
    PVIP_FMT_SMPTE = 2'b00,
    PVIP_FMT_THRU  = 2'b01,
    PVIP_FMT_ASI   = 2'b10,
    PVIP_FMT_BAD   = 2'b11
  } pvip_fmt_t;

  // trs search: the word taken in state XYZ is the XYZ word
  typedef enum logic [1:0] {
    PVIP_TRS_IDLE = 2'b00,
    PVIP_TRS_ONE  = 2'b01,
    PVIP_TRS_TWO  = 2'b10,
    PVIP_TRS_XYZ  = 2'b11
  } pvip_trs_t;

  typedef struct packed {
    logic [9:0] data;
    pvip_fmt_t  fmt;
    logic       chroma;
    logic       trs;
    logic       f;
    logic       v;
    logic       h;
    logic       active;
  } pvip_word_t;

  typedef struct packed {
    logic [9:0] din;
    logic       fpin;
    logic       hpin;
    logic       vpin;
    logic       clk;
  } pvip_pins_t;

endpackage

// File: hw/pvip_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module pvip_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      wptr_next;
  logic [AW:0]      rptr_reg;
  logic [AW:0]      rptr_next;
  logic             push;
  logic             pop;

  // pointers carry one extra wrap bit so full and empty are exact
  assign o_valid = (wptr_reg != rptr_reg);
  assign o_ready = (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]) || (wptr_reg[AW] == rptr_reg[AW]);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rptr_reg[AW-1:0]];

  // pointer update, flush drops everything queued
  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    if (i_flush) begin
      wptr_next = '0;
      rptr_next = '0;
    end else begin
      if (push) begin
        wptr_next = wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_next = rptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge i_clock) begin
    if (push && !i_flush) begin
      mem[wptr_reg[AW-1:0]] <= i_data;
    end
  end

endmodule

`default_nettype wire

// File: verification/pvip_top_props.sv
`include "pvip_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module pvip_top_props
  import pvip_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`PVIP_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]             i_pwdata,
  input  wire logic                    i_pclk,
  input  wire pvip_word_t              o_word,
  input  wire logic                    o_word_valid,
  input  wire logic                    i_word_ready
);
  logic [7:0] ctl_reg, ctl_next;
  logic [2:0] quiet_reg, quiet_next;
  logic [2:0] age_reg, age_next;
  logic       pclk_reg;
  logic       ctl_wr;
  logic       ok;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // mode mirror; checks wait until a mode write has flushed old words
  assign ctl_wr = i_psel && i_penable && i_pwrite && i_paddr == `PVIP_CTRL_OFS;
  assign ok     = quiet_reg == 3'h4;
  always_comb begin
    ctl_next   = ctl_wr ? i_pwdata[7:0] : ctl_reg;
    quiet_next = ctl_wr ? 3'h0 : ((quiet_reg == 3'h4) ? quiet_reg : quiet_reg + 3'h1);
    age_next   = (i_pclk && !pclk_reg) ? 3'h0 : ((age_reg == 3'h7) ? age_reg : age_reg + 3'h1);
  end

  // helper registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctl_reg   <= `PVIP_CTRL_RESET;
      quiet_reg <= 3'h4;
      age_reg   <= 3'h7;
      pclk_reg  <= 1'b0;
    end else begin
      ctl_reg   <= ctl_next;
      quiet_reg <= quiet_next;
      age_reg   <= age_next;
      pclk_reg  <= i_pclk;
    end
  end

  property p_no_bad; o_word_valid |-> o_word.fmt != PVIP_FMT_BAD; endproperty
  a_no_bad: assert property (p_no_bad)
    else $error("bad format word offered");
  property p_asi_sd; o_word_valid && ok && o_word.fmt == PVIP_FMT_ASI |-> ctl_reg[0]; endproperty
  a_asi_sd: assert property (p_asi_sd)
    else $error("asi word at hd rate");
  property p_thru; o_word_valid && ok && !ctl_reg[2] && !ctl_reg[3] |-> o_word.fmt == PVIP_FMT_THRU;
  endproperty
  a_thru: assert property (p_thru)
    else $error("data-through word has wrong format");
  property p_luma; o_word_valid && ok && ctl_reg[2] && ctl_reg[1] |-> !o_word.chroma; endproperty
  a_luma: assert property (p_luma)
    else $error("chroma word on 20-bit bus");
  property p_trs; o_word_valid && o_word.trs |-> !o_word.chroma && !o_word.active; endproperty
  a_trs: assert property (p_trs)
    else $error("timing word marked chroma or active");
  property p_hold; o_word_valid && !i_word_ready && !ctl_wr |=> o_word_valid && $stable(o_word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered word changed before pop");
  property p_late; $rose(o_word_valid) |-> age_reg <= 3'h5; endproperty
  a_late: assert property (p_late)
    else $error("word appeared without a recent pclk rise");
  property p_sync;
    o_word_valid && ok && ctl_reg[4] && !ctl_reg[5] && !o_word.trs |-> !o_word.f &&
      (o_word.active == (!o_word.h && !o_word.v));
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync style timing bits wrong");

  c_chroma: cover property (o_word_valid && o_word.chroma);
  c_asi: cover property (o_word_valid && o_word.fmt == PVIP_FMT_ASI);
  c_trs_f: cover property (o_word_valid && o_word.trs && o_word.f);
endmodule

bind pvip_top pvip_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) props_u (
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pclk(i_pclk),
  .o_word(o_word), .o_word_valid(o_word_valid), .i_word_ready(i_word_ready));

`default_nettype wire

// File: verification/pvip_src_model.sv
`timescale 1ns/10ps
`default_nettype none

// video source; pclk stands low between words
module pvip_src_model (
  input  wire logic       i_clock,
  output logic            o_pclk,
  output logic [9:0]      o_din,
  output logic            o_fpin,
  output logic            o_hpin,
  output logic            o_vpin
);
  initial begin
    o_pclk = 1'b0;
    o_din  = 10'h000;
    o_fpin = 1'b0;
    o_hpin = 1'b0;
    o_vpin = 1'b0;
  end

  // one word per 160 ns pclk period, modes untouched meanwhile
  task automatic send(input logic [9:0] d, input logic f, input logic h, input logic v);
    @(posedge i_clock);
    o_din  <= d;
    o_fpin <= f;
    o_hpin <= h;
    o_vpin <= v;
    // seven edges here plus the task's first edge keep pclk low for 80 ns
    repeat (7) @(posedge i_clock);
    o_pclk <= 1'b1;
    repeat (8) @(posedge i_clock);
    o_pclk <= 1'b0;
    o_din  <= ~d;     // hold over: stale data must not look valid
  endtask
endmodule

`default_nettype wire

// File: verification/pvip_top_tb.sv
`include "pvip_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module pvip_top_tb
  import pvip_pkg::*;
;
  logic        i_clock, i_rst, psel, penable, pwrite, pready, pslverr, ready, wvalid, err;
  logic        pclk, fpin, hpin, vpin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  din;
  pvip_word_t  word;
  int          error_cnt, cmp_count;

  pvip_top #(.FIFO_DEPTH(8)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_pclk(pclk), .i_din(din),
    .i_field_or_active_pin(fpin), .i_hflag_or_hsync_pin(hpin),
    .i_vflag_or_vsync_pin(vpin), .o_word(word), .o_word_valid(wvalid), .i_word_ready(ready));
  pvip_src_model src_u (.i_clock(i_clock), .o_pclk(pclk), .o_din(din), .o_fpin(fpin),
    .o_hpin(hpin), .o_vpin(vpin));

  // ******
  // helpers
  // ******
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // apb master: request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
    chk("pslverr", {31'h0, x}, {31'h0, err});
  endtask
  // b packs chroma, trs, f, v, h, active
  function automatic pvip_word_t mk(input logic [9:0] d, input pvip_fmt_t fm, input logic [5:0] b);
    return {d, fm, b};
  endfunction
  // consumer: wait for a word, compare, pop it
  task automatic pop(input pvip_word_t e, input logic full);
    int n = 0;
    while (wvalid !== 1'b1 && n < 60) begin
      @(posedge i_clock);
      n++;
    end
    if (full) chk("word", {14'h0, e}, {14'h0, word});
    else chk("data_fmt", {20'h0, e.data, e.fmt}, {20'h0, word.data, word.fmt});
    ready <= 1'b1;
    @(posedge i_clock);
    ready <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic trs(input logic [9:0] x, input logic f, input logic h);
    src_u.send(10'h3ff, f, h, 1'b0);
    src_u.send(10'h000, f, h, 1'b0);
    src_u.send(10'h000, f, h, 1'b0);
    src_u.send(x, f, h, 1'b0);
  endtask
  task automatic pop_trs(input logic [9:0] x, input logic [5:0] b, input logic full);
    pop(mk(10'h3ff, PVIP_FMT_SMPTE, b), full);
    pop(mk(10'h000, PVIP_FMT_SMPTE, b), full);
    pop(mk(10'h000, PVIP_FMT_SMPTE, b), full);
    pop(mk(x, PVIP_FMT_SMPTE, b), 1'b1);
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    tally_and_finish();
  end

  // ******
  // tests
  // ******
  initial begin
    i_rst = 1'b1;
    {psel, penable, pwrite, ready} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    rd_chk(12'h000, 32'h0000_00c4, 1'b0);
    rd_chk(12'h004, 32'h0000_0004, 1'b0);
    rd_chk(12'h008, 32'h0000_0000, 1'b0);
    rd_chk(12'h00c, 32'h0000_0000, 1'b1);
    // hd 20-bit smpte, field pin high forces F in the timing word
    apb(1'b1, 12'h000, 32'h0000_00c6);
    trs(10'h200, 1'b1, 1'b1);
    src_u.send(10'h201, 1'b1, 1'b0, 1'b0);
    src_u.send(10'h1fe, 1'b1, 1'b0, 1'b0);
    pop_trs(10'h300, 6'h1a, 1'b1);
    pop(mk(10'h201, PVIP_FMT_SMPTE, 6'h09), 1'b1);
    pop(mk(10'h1fe, PVIP_FMT_SMPTE, 6'h09), 1'b1);
    // hd 10-bit smpte: chroma and luma alternate after the timing word
    apb(1'b1, 12'h000, 32'h0000_00c4);
    trs(10'h200, 1'b0, 1'b1);
    src_u.send(10'h111, 1'b0, 1'b0, 1'b0);
    src_u.send(10'h222, 1'b0, 1'b0, 1'b0);
    src_u.send(10'h0aa, 1'b0, 1'b0, 1'b0);
    pop_trs(10'h200, 6'h12, 1'b1);
    pop(mk(10'h111, PVIP_FMT_SMPTE, 6'h21), 1'b1);
    pop(mk(10'h222, PVIP_FMT_SMPTE, 6'h01), 1'b1);
    pop(mk(10'h0aa, PVIP_FMT_SMPTE, 6'h21), 1'b1);
    // sync style: pins mean active enable and sync
    apb(1'b1, 12'h000, 32'h0000_00d6);
    src_u.send(10'h123, 1'b1, 1'b0, 1'b0);
    src_u.send(10'h321, 1'b0, 1'b1, 1'b1);
    pop(mk(10'h123, PVIP_FMT_SMPTE, 6'h01), 1'b1);
    pop(mk(10'h321, PVIP_FMT_SMPTE, 6'h06), 1'b1);
    // auto detect: pins all high yet timing follows the timing word
    apb(1'b1, 12'h000, 32'h0000_00e6);
    trs(10'h200, 1'b1, 1'b1);
    src_u.send(10'h155, 1'b1, 1'b1, 1'b1);
    pop_trs(10'h200, 6'h10, 1'b0);
    pop(mk(10'h155, PVIP_FMT_SMPTE, 6'h01), 1'b1);
    // data-through in every rate and width
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, 32'h0000_00c0 | k);
      src_u.send(10'h2a5, 1'b0, 1'b0, 1'b0);
      pop(mk(10'h2a5, PVIP_FMT_THRU, 6'h00), 1'b0);
    end
    // asi accepted at sd rate, refused at hd rate
    apb(1'b1, 12'h000, 32'h0000_00c9);
    src_u.send(10'h0f0, 1'b0, 1'b0, 1'b0);
    pop(mk(10'h0f0, PVIP_FMT_ASI, 6'h00), 1'b0);
    apb(1'b1, 12'h000, 32'h0000_00c8);
    rd_chk(12'h004, 32'h0000_0006, 1'b0);
    src_u.send(10'h0f0, 1'b0, 1'b0, 1'b0);
    chk("word_valid", 32'h0000_0000, {31'h0, wvalid});
    // overflow: nine words into eight places with the consumer stalled
    apb(1'b1, 12'h000, 32'h0000_00c0);
    for (int k = 0; k < 9; k++) src_u.send(10'(10'h100 + k), 1'b0, 1'b0, 1'b0);
    rd_chk(12'h004, 32'h0000_0001, 1'b0);
    for (int k = 0; k < 8; k++) pop(mk(10'(10'h100 + k), PVIP_FMT_THRU, 6'h00), 1'b0);
    chk("word_valid", 32'h0000_0000, {31'h0, wvalid});
    apb(1'b1, 12'h004, 32'h0000_0001);
    rd_chk(12'h004, 32'h0000_0004, 1'b0);
    // port disabled: words are ignored and the accept count stands still
    apb(1'b1, 12'h000, 32'h0000_0040);
    src_u.send(10'h0f0, 1'b0, 1'b0, 1'b0);
    chk("word_valid", 32'h0000_0000, {31'h0, wvalid});
    rd_chk(12'h008, 32'h0000_0021, 1'b0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
